//--- adc_mode_pkg.sv
package adc_mode_pkg;

    // clock periods, used to turn times into cycle counts
    localparam int MCLK_PERIOD_NS = 20;
    localparam int SAMPLE_PERIOD_NS = 64;

    // wake-up times and the slowest sample clock still counted as running
    localparam int FAST_WAKE_NS = 100;
    localparam int SLOW_WAKE_NS = 15000;
    localparam int MIN_RATE_PERIOD_NS = 1000;

    // least times round up, the stop detector window rounds down
    localparam int FAST_WAKE_CYC = (FAST_WAKE_NS + SAMPLE_PERIOD_NS - 1) / SAMPLE_PERIOD_NS;
    localparam int SLOW_WAKE_CYC = (SLOW_WAKE_NS + SAMPLE_PERIOD_NS - 1) / SAMPLE_PERIOD_NS;
    localparam int STOP_CYC = MIN_RATE_PERIOD_NS / MCLK_PERIOD_NS;
    localparam int WAKE_W = 8;
    localparam int STOP_W = 8;

    // sample path
    localparam int SAMPLE_W = 14;
    localparam int LATENCY = 14;

    // power state codes
    localparam logic [2:0] PWR_NORMAL = 3'h0;
    localparam logic [2:0] PWR_HIZ_A = 3'h1;
    localparam logic [2:0] PWR_HIZ_B = 3'h2;
    localparam logic [2:0] PWR_HIZ_AB = 3'h3;
    localparam logic [2:0] PWR_GLOBAL = 3'h4;
    localparam logic [2:0] PWR_STBY_A = 3'h5;
    localparam logic [2:0] PWR_STBY_B = 3'h6;
    localparam logic [2:0] PWR_MUX = 3'h7;

    // register byte addresses
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;

    // config register fields
    localparam int CFG_CODE_LSB = 0;
    localparam int CFG_PINS_BIT = 3;
    localparam int CFG_COARSE_BIT = 4;
    localparam int CFG_FINE_LSB = 5;
    localparam int CFG_REF_BIT = 9;
    localparam int CFG_DDR_BIT = 10;
    localparam logic [3:0] FINE_MAX = 4'hc;

    // status register fields
    localparam int STS_CODE_LSB = 0;
    localparam int STS_STOP_BIT = 3;
    localparam int STS_VALID_A_BIT = 4;
    localparam int STS_VALID_B_BIT = 5;
    localparam int STS_DDR_BIT = 6;

    // values after reset
    localparam logic [2:0] CODE_RESET = 3'h0;
    localparam logic [3:0] FINE_RESET = 4'h0;

    // settings handed to the sample clock domain as one word
    typedef struct packed {
        logic [2:0] code;
        logic ddr;
    } cfg_s;

endpackage : adc_mode_pkg

//--- dual_adc_mode_control.sv
// Function
// - power code from register or three pins
// - codes 001-011 tristate channel output buffers
// - code 100 powers down all, slow wake
// - codes 101/110 put one channel standby
// - code 111 interleaves both channels on B
// - sample clock below 1 MSPS forces low power
// - coarse 3.5 dB, fine 0-6 dB in 0.5
// - gain is 0 dB after reset
// - reference mode bit; external makes common-mode input
// - output interface from register or serial-enable pin
// - 14-bit samples per channel, shared output clock
// - one pin per bit, word every cycle
// - output appears 14 sample cycles after capture
module dual_adc_mode_control (
    // system clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // parallel configuration pins
    input wire logic MODE_PIN_MSB,
    input wire logic MODE_PIN_MID,
    input wire logic MODE_PIN_LSB,
    input wire logic SERIAL_ENABLE_PIN,
    // analog and interface controls
    output logic GAIN_COARSE_EN,
    output logic [3:0] GAIN_FINE,
    output logic REF_EXTERNAL,
    output logic COMMON_MODE_PIN_OE,
    output logic IFACE_DDR,
    output logic LOW_POWER,
    // sample clock domain
    input wire logic SAMPLE_CLK,
    input wire logic [13:0] CONV_A,
    input wire logic [13:0] CONV_B,
    output logic [13:0] DATA_A,
    output logic DATA_A_OE,
    output logic [13:0] DATA_B,
    output logic DATA_B_OE,
    output logic VALID_A,
    output logic VALID_B,
    output logic MUX_CHANNEL_B,
    output logic OUTPUT_SAMPLE_CLK
);

    // address match on the low byte of the address
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        addr_is = (a == off);
    endfunction : addr_is

    // per channel effect of a code: {powered down, buffer off}
    function automatic logic [1:0] chan_state(input logic [2:0] code, input logic chan_b);
        logic down;
        logic hiz;
        down = (code == adc_mode_pkg::PWR_GLOBAL)
            || (code == (chan_b ? adc_mode_pkg::PWR_STBY_B : adc_mode_pkg::PWR_STBY_A));
        hiz = (code == adc_mode_pkg::PWR_HIZ_AB)
            || (code == (chan_b ? adc_mode_pkg::PWR_HIZ_B : adc_mode_pkg::PWR_HIZ_A));
        chan_state = {down, hiz};
    endfunction : chan_state

    // ---------------- system clock domain ----------------
    logic [3:0] pin_meta; // first stage, read only by pin_sync
    logic [3:0] pin_sync; // msb, mid, lsb, serial enable
    logic ap_write; // pending write data phase
    logic ap_read;
    logic [7:0] ap_addr;
    logic [2:0] cfg_code; // register power code
    logic cfg_pins; // take code and interface from pins
    logic cfg_coarse;
    logic [3:0] cfg_fine;
    logic cfg_ref;
    logic cfg_ddr;
    logic [2:0] next_code;
    logic next_pins;
    logic next_coarse;
    logic [3:0] next_fine;
    logic next_ref;
    logic next_ddr;
    logic [2:0] eff_code; // code actually in force
    logic eff_ddr;
    adc_mode_pkg::cfg_s cfg_hold; // word offered to the sample domain
    logic req_tgl;
    logic ack_meta;
    logic ack_sync;
    logic smp_ack_tgl; // echo toggle from the sample domain
    logic smp_hb; // toggles on every rising sample edge
    logic hb_meta; // sample clock heartbeat crossing
    logic hb_sync;
    logic hb_last;
    logic [adc_mode_pkg::STOP_W-1:0] stop_cnt;
    logic [1:0] vld_meta;
    logic [1:0] vld_sync;
    logic accept;

    assign accept = HSEL && HTRANS[1] && HREADY;

    // pins come from outside: two flops before use
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else begin
            pin_meta <= {MODE_PIN_MSB, MODE_PIN_MID, MODE_PIN_LSB, SERIAL_ENABLE_PIN};
            pin_sync <= pin_meta;
        end
    end

    // address phase capture, single words only
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            ap_write <= 1'b0;
            ap_read <= 1'b0;
            ap_addr <= 8'h00;
        end else begin
            ap_write <= accept && HWRITE;
            ap_read <= accept && !HWRITE;
            ap_addr <= HADDR[7:0];
        end
    end

    // zero wait state, always okay
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    // config write lands in the data phase
    always_comb begin
        next_code = cfg_code;
        next_pins = cfg_pins;
        next_coarse = cfg_coarse;
        next_fine = cfg_fine;
        next_ref = cfg_ref;
        next_ddr = cfg_ddr;
        if (ap_write && addr_is(ap_addr, adc_mode_pkg::ADDR_CONFIG)) begin
            next_code = HWDATA[adc_mode_pkg::CFG_CODE_LSB +: 3];
            next_pins = HWDATA[adc_mode_pkg::CFG_PINS_BIT];
            next_coarse = HWDATA[adc_mode_pkg::CFG_COARSE_BIT];
            // fine steps above 6 dB are refused, old step kept
            if (HWDATA[adc_mode_pkg::CFG_FINE_LSB +: 4] <= adc_mode_pkg::FINE_MAX) begin
                next_fine = HWDATA[adc_mode_pkg::CFG_FINE_LSB +: 4];
            end
            next_ref = HWDATA[adc_mode_pkg::CFG_REF_BIT];
            next_ddr = HWDATA[adc_mode_pkg::CFG_DDR_BIT];
        end
    end

    // config register, all zero gives normal mode and 0 dB
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            cfg_code <= adc_mode_pkg::CODE_RESET;
            cfg_pins <= 1'b0;
            cfg_coarse <= 1'b0;
            cfg_fine <= adc_mode_pkg::FINE_RESET;
            cfg_ref <= 1'b0;
            cfg_ddr <= 1'b0;
        end else begin
            cfg_code <= next_code;
            cfg_pins <= next_pins;
            cfg_coarse <= next_coarse;
            cfg_fine <= next_fine;
            cfg_ref <= next_ref;
            cfg_ddr <= next_ddr;
        end
    end

    // source select: pins carry msb first
    always_comb begin
        eff_code = cfg_pins ? pin_sync[3:1] : cfg_code;
        eff_ddr = cfg_pins ? pin_sync[0] : cfg_ddr;
    end

    // read data registered at the address phase, write forwarded
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            HRDATA <= 32'h0000_0000;
        end else if (accept && !HWRITE) begin
            HRDATA <= 32'h0000_0000;
            if (addr_is(HADDR[7:0], adc_mode_pkg::ADDR_CONFIG)) begin
                HRDATA[adc_mode_pkg::CFG_CODE_LSB +: 3] <= next_code;
                HRDATA[adc_mode_pkg::CFG_PINS_BIT] <= next_pins;
                HRDATA[adc_mode_pkg::CFG_COARSE_BIT] <= next_coarse;
                HRDATA[adc_mode_pkg::CFG_FINE_LSB +: 4] <= next_fine;
                HRDATA[adc_mode_pkg::CFG_REF_BIT] <= next_ref;
                HRDATA[adc_mode_pkg::CFG_DDR_BIT] <= next_ddr;
            end else if (addr_is(HADDR[7:0], adc_mode_pkg::ADDR_STATUS)) begin
                HRDATA[adc_mode_pkg::STS_CODE_LSB +: 3] <= eff_code;
                HRDATA[adc_mode_pkg::STS_STOP_BIT] <= LOW_POWER;
                HRDATA[adc_mode_pkg::STS_VALID_A_BIT] <= vld_sync[0];
                HRDATA[adc_mode_pkg::STS_VALID_B_BIT] <= vld_sync[1];
                HRDATA[adc_mode_pkg::STS_DDR_BIT] <= eff_ddr;
            end
        end
    end

    // analog controls; common-mode pin is an input in external mode
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            GAIN_COARSE_EN <= 1'b0;
            GAIN_FINE <= adc_mode_pkg::FINE_RESET;
            REF_EXTERNAL <= 1'b0;
            COMMON_MODE_PIN_OE <= 1'b1;
            IFACE_DDR <= 1'b0;
        end else begin
            GAIN_COARSE_EN <= cfg_coarse;
            GAIN_FINE <= cfg_fine;
            REF_EXTERNAL <= cfg_ref;
            COMMON_MODE_PIN_OE <= !cfg_ref;
            IFACE_DDR <= eff_ddr;
        end
    end

    // toggle handshake: a new word is offered only once the last was taken
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            cfg_hold <= '0;
            req_tgl <= 1'b0;
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
        end else begin
            ack_meta <= smp_ack_tgl;
            ack_sync <= ack_meta;
            if (ack_sync == req_tgl && (cfg_hold.code != eff_code || cfg_hold.ddr != eff_ddr)) begin
                cfg_hold <= '{code: eff_code, ddr: eff_ddr};
                req_tgl <= !req_tgl;
            end
        end
    end

    // stopped sample clock: no heartbeat change within one slow period
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            hb_meta <= 1'b0;
            hb_sync <= 1'b0;
            hb_last <= 1'b0;
            stop_cnt <= '0;
            LOW_POWER <= 1'b0;
        end else begin
            hb_meta <= smp_hb;
            hb_sync <= hb_meta;
            hb_last <= hb_sync;
            if (hb_sync != hb_last) begin
                stop_cnt <= '0;
                LOW_POWER <= 1'b0;
            end else if (stop_cnt == adc_mode_pkg::STOP_W'(adc_mode_pkg::STOP_CYC)) begin
                LOW_POWER <= 1'b1;
            end else begin
                stop_cnt <= stop_cnt + 1'b1;
            end
        end
    end

    // valid flags back for status
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            vld_meta <= 2'h0;
            vld_sync <= 2'h0;
        end else begin
            vld_meta <= {VALID_B, VALID_A};
            vld_sync <= vld_meta;
        end
    end

    // ---------------- sample clock domain ----------------
    logic rst_meta; // reset release synchroniser
    logic srst;
    logic req_meta;
    logic req_sync;
    logic req_last;
    adc_mode_pkg::cfg_s cfg_live;
    logic lp_meta;
    logic lp_sync;
    logic oclk_n; // follows smp_hb on the falling edge
    logic mux_phase;
    logic [13:0] pipe_a [0:adc_mode_pkg::LATENCY-1];
    logic [13:0] pipe_b [0:adc_mode_pkg::LATENCY-1];
    logic [1:0] down; // channel powered down
    logic [1:0] hiz; // channel buffer disabled by code
    logic [1:0] reduced;
    logic mux_on;
    logic [adc_mode_pkg::WAKE_W-1:0] wake_cnt [0:1];

    // release the sample domain reset on its own clock
    always_ff @(posedge SAMPLE_CLK or posedge RESET) begin
        if (RESET) begin
            rst_meta <= 1'b1;
            srst <= 1'b1;
        end else begin
            rst_meta <= 1'b0;
            srst <= rst_meta;
        end
    end

    // take the offered word on a request edge, echo the toggle
    always_ff @(posedge SAMPLE_CLK or posedge srst) begin
        if (srst) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_last <= 1'b0;
            smp_ack_tgl <= 1'b0;
            cfg_live <= '0;
            lp_meta <= 1'b0;
            lp_sync <= 1'b0;
        end else begin
            req_meta <= req_tgl;
            req_sync <= req_meta;
            req_last <= req_sync;
            lp_meta <= LOW_POWER;
            lp_sync <= lp_meta;
            if (req_sync != req_last) begin
                cfg_live <= cfg_hold;
                smp_ack_tgl <= req_sync;
            end
        end
    end

    // decode of the live code; clock stop powers both channels down, output buffers stay on
    always_comb begin
        mux_on = (cfg_live.code == adc_mode_pkg::PWR_MUX) && !lp_sync;
        {down[0], hiz[0]} = chan_state(cfg_live.code, 1'b0);
        {down[1], hiz[1]} = chan_state(cfg_live.code, 1'b1);
        down = down | {2{lp_sync}};
        reduced = down | hiz;
    end

    // latency pipeline: stage 0 captures, output register is the fifteenth flop
    always_ff @(posedge SAMPLE_CLK or posedge srst) begin
        if (srst) begin
            pipe_a[0] <= 14'h0000;
            pipe_b[0] <= 14'h0000;
        end else begin
            pipe_a[0] <= CONV_A;
            pipe_b[0] <= CONV_B;
        end
    end

    genvar s;
    generate
        for (s = 1; s < adc_mode_pkg::LATENCY; s++) begin : g_stage
            always_ff @(posedge SAMPLE_CLK or posedge srst) begin
                if (srst) begin
                    pipe_a[s] <= 14'h0000;
                    pipe_b[s] <= 14'h0000;
                end else begin
                    pipe_a[s] <= pipe_a[s-1];
                    pipe_b[s] <= pipe_b[s-1];
                end
            end
        end
    endgenerate

    // output words; a powered-down channel drives zeros
    always_ff @(posedge SAMPLE_CLK or posedge srst) begin
        if (srst) begin
            DATA_A <= 14'h0000;
            DATA_B <= 14'h0000;
            MUX_CHANNEL_B <= 1'b1;
            mux_phase <= 1'b0;
        end else begin
            DATA_A <= down[0] ? 14'h0000 : pipe_a[adc_mode_pkg::LATENCY-1];
            mux_phase <= mux_on ? !mux_phase : 1'b0;
            if (mux_on && !mux_phase) begin
                DATA_B <= pipe_a[adc_mode_pkg::LATENCY-1];
                MUX_CHANNEL_B <= 1'b0;
            end else begin
                DATA_B <= down[1] ? 14'h0000 : pipe_b[adc_mode_pkg::LATENCY-1];
                MUX_CHANNEL_B <= 1'b1;
            end
        end
    end

    // output enables; channel a pins float in multiplexed mode
    always_ff @(posedge SAMPLE_CLK or posedge srst) begin
        if (srst) begin
            DATA_A_OE <= 1'b1;
            DATA_B_OE <= 1'b1;
        end else begin
            DATA_A_OE <= !(hiz[0] || cfg_live.code == adc_mode_pkg::PWR_GLOBAL || mux_on);
            DATA_B_OE <= !(hiz[1] || cfg_live.code == adc_mode_pkg::PWR_GLOBAL);
        end
    end

    // wake counters; a slow wake is never shortened by a later fast state
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_wake
            always_ff @(posedge SAMPLE_CLK or posedge srst) begin
                if (srst) begin
                    wake_cnt[c] <= '0;
                end else if (reduced[c]) begin
                    if (down[c] && (cfg_live.code == adc_mode_pkg::PWR_GLOBAL || lp_sync)) begin
                        wake_cnt[c] <= adc_mode_pkg::WAKE_W'(adc_mode_pkg::SLOW_WAKE_CYC);
                    end else if (wake_cnt[c] < adc_mode_pkg::WAKE_W'(adc_mode_pkg::FAST_WAKE_CYC)) begin
                        wake_cnt[c] <= adc_mode_pkg::WAKE_W'(adc_mode_pkg::FAST_WAKE_CYC);
                    end
                end else if (wake_cnt[c] != '0) begin
                    wake_cnt[c] <= wake_cnt[c] - 1'b1;
                end
            end
        end
    endgenerate

    // valid only when active and the wake interval has run out
    always_ff @(posedge SAMPLE_CLK or posedge srst) begin
        if (srst) begin
            VALID_A <= 1'b0;
            VALID_B <= 1'b0;
        end else begin
            VALID_A <= !reduced[0] && (wake_cnt[0] == '0);
            VALID_B <= !reduced[1] && (wake_cnt[1] == '0);
        end
    end

    // output clock: two flops, rising edge in the middle of each data word
    always_ff @(posedge SAMPLE_CLK or posedge srst) begin
        if (srst) begin
            smp_hb <= 1'b0;
        end else begin
            smp_hb <= !smp_hb;
        end
    end

    always_ff @(negedge SAMPLE_CLK or posedge srst) begin
        if (srst) begin
            oclk_n <= 1'b0;
        end else begin
            oclk_n <= smp_hb;
        end
    end

    // receiver latches data on the rising edge of this clock
    assign OUTPUT_SAMPLE_CLK = !(smp_hb ^ oclk_n);

endmodule : dual_adc_mode_control

//--- mode_checker_properties.sv
module mode_checker (
    // system side
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    input wire logic GAIN_COARSE_EN,
    input wire logic [3:0] GAIN_FINE,
    input wire logic REF_EXTERNAL,
    input wire logic COMMON_MODE_PIN_OE,
    input wire logic LOW_POWER,
    // sample side
    input wire logic SAMPLE_CLK,
    input wire logic [13:0] CONV_B,
    input wire logic [13:0] DATA_B,
    input wire logic DATA_A_OE,
    input wire logic DATA_B_OE,
    input wire logic VALID_B,
    input wire logic MUX_CHANNEL_B,
    input wire logic OUTPUT_SAMPLE_CLK
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] idle_cnt; // mclk cycles with the sample clock standing
    logic last_sclk; // sample clock seen one mclk earlier

    // measure how long the sample clock has been still
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            idle_cnt <= 8'h00;
            last_sclk <= 1'b0;
        end else begin
            last_sclk <= SAMPLE_CLK;
            // saturate so a long stop never wraps back to zero
            if (SAMPLE_CLK != last_sclk) begin
                idle_cnt <= 8'h00;
            end else if (idle_cnt != 8'hff) begin
                idle_cnt <= idle_cnt + 8'h01;
            end
        end
    end

    a_gain_reset: assert property (
        @(posedge MCLK) $fell(RESET) |-> GAIN_FINE == 4'h0 && !GAIN_COARSE_EN)
        else $error("gain not zero after reset");
    a_gain_write: assert property (
        @(posedge MCLK) disable iff (RESET)
        (HSEL && HTRANS[1] && HWRITE && HREADY && HADDR[7:0] == 8'h00)
        ##1 (HWDATA[8:5] <= 4'hc) |=> ##1 (GAIN_FINE == $past(HWDATA[8:5], 2)
        && GAIN_COARSE_EN == $past(HWDATA[4], 2) && REF_EXTERNAL == $past(HWDATA[9], 2)))
        else $error("config write not applied");
    a_fine_range: assert property (
        @(posedge MCLK) disable iff (RESET) GAIN_FINE <= 4'hc)
        else $error("fine gain beyond range");
    a_ref_pin: assert property (
        @(posedge MCLK) disable iff (RESET) REF_EXTERNAL != COMMON_MODE_PIN_OE)
        else $error("common-mode pin drive wrong");
    a_stop_low: assert property (
        @(posedge MCLK) disable iff (RESET) idle_cnt == 8'h46 |-> LOW_POWER)
        else $error("stopped clock not flagged");
    a_outclk_phase: assert property (
        @(posedge SAMPLE_CLK) disable iff (RESET) OUTPUT_SAMPLE_CLK)
        else $error("output clock phase wrong");
    a_data_latency: assert property (
        @(posedge SAMPLE_CLK) disable iff (RESET)
        VALID_B && DATA_A_OE && $past(VALID_B, 15) |-> DATA_B == $past(CONV_B, 15))
        else $error("output word latency wrong");
    a_mux_pairs: assert property (
        @(posedge SAMPLE_CLK) disable iff (RESET)
        !MUX_CHANNEL_B |-> !DATA_A_OE ##1 MUX_CHANNEL_B)
        else $error("multiplexed order wrong");
    a_valid_driven: assert property (
        @(posedge SAMPLE_CLK) disable iff (RESET) VALID_B |-> DATA_B_OE)
        else $error("valid on undriven bus");

    c_mux: cover property (@(posedge SAMPLE_CLK) disable iff (RESET) !MUX_CHANNEL_B);
    c_stop: cover property (@(posedge MCLK) disable iff (RESET) $rose(LOW_POWER));
    c_wake: cover property (@(posedge SAMPLE_CLK) disable iff (RESET) $rose(VALID_B));
endmodule : mode_checker

//--- capture_model.sv
module capture_model (
    // output link from the converter
    input wire logic out_clk,
    input wire logic [13:0] data_a,
    input wire logic [13:0] data_b,
    // words as the receiver latched them
    output logic [13:0] rx_a,
    output logic [13:0] rx_b
);
    timeunit 1ns;
    timeprecision 100ps;

    // latch mid-word on the rising output clock, one pin per bit
    always_ff @(posedge out_clk) begin
        rx_a <= data_a;
        rx_b <= data_b;
    end
endmodule : capture_model

//--- testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, reset, hsel, hwrite, sclk, srun, pin_msb, pin_mid, pin_lsb, sen_pin, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, rdata, hrdata;
    logic [13:0] conv, data_a, data_b, rx_a, rx_b;
    logic hreadyout, coarse, ref_ext, cm_oe, ddr, low_pwr, oe_a, oe_b, val_a, val_b, out_clk;
    logic [3:0] fine;
    int error_cnt, checks_done, n;
    // expected {oe_a, oe_b, valid_a, valid_b} per power code
    localparam logic [3:0] LINK_EXP [8] = '{4'hf, 4'h5, 4'ha, 4'h0, 4'h0, 4'hd, 4'he, 4'h7};

    dual_adc_mode_control DUT (.MCLK(mclk), .RESET(reset), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .MODE_PIN_MSB(pin_msb),
        .MODE_PIN_MID(pin_mid), .MODE_PIN_LSB(pin_lsb), .SERIAL_ENABLE_PIN(sen_pin),
        .GAIN_COARSE_EN(coarse), .GAIN_FINE(fine), .REF_EXTERNAL(ref_ext),
        .COMMON_MODE_PIN_OE(cm_oe), .IFACE_DDR(ddr), .LOW_POWER(low_pwr), .SAMPLE_CLK(sclk),
        .CONV_A(conv), .CONV_B(~conv), .DATA_A(data_a), .DATA_A_OE(oe_a), .DATA_B(data_b),
        .DATA_B_OE(oe_b), .VALID_A(val_a), .VALID_B(val_b), .MUX_CHANNEL_B(),
        .OUTPUT_SAMPLE_CLK(out_clk));
    capture_model rx (.out_clk(out_clk), .data_a(data_a), .data_b(data_b), .rx_a(rx_a),
        .rx_b(rx_b));

    // compare and count
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task print_verdict();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // one rising edge with hready high, bounded
    task step_ready();
        int k;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin
            chk("hready wait", 0, 1);
            print_verdict();
        end
    endtask : step_ready

    // single word transfer, read data left in rdata
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        step_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        step_ready();
        rdata = hrdata;
        chk("okay resp", hresp, 0);
    endtask : bus

    // sample cycles until both channels are valid again
    task wait_valid();
        n = 0;
        while (!(val_a === 1'b1 && val_b === 1'b1) && n < 400) begin
            @(posedge sclk);
            n++;
        end
        if (n >= 400) begin
            chk("wake wait", 0, 1);
            print_verdict();
        end
    endtask : wait_valid

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // sample clock parks low while stopped, phase unrelated to mclk
    initial begin
        sclk = 1'b0;
        #7;
        forever begin
            #32;
            if (srun || sclk) sclk = ~sclk;
        end
    end
    // converter words count up so latency shows as an offset
    always @(posedge sclk) conv <= conv + 14'h001;
    // hang guard
    initial begin
        #300us;
        chk("run time", 0, 1);
        print_verdict();
    end

    initial begin
        {reset, srun} = 2'b11;
        {hsel, hwrite, pin_msb, pin_mid, pin_lsb, sen_pin} = 6'h00;
        {htrans, haddr, hwdata, conv} = '0;
        error_cnt = 0;
        checks_done = 0;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        bus(0, 8'h00, 0);
        chk("config reset", rdata, 0);
        chk("gain reset", {coarse, fine}, 5'h00);
        bus(0, 8'h08, 0);
        chk("unmapped read", rdata, 0);
        // coarse, fine 12, external ref, ddr
        bus(1, 8'h00, 32'h0000_0790);
        repeat (2) @(negedge mclk);
        chk("gain set", {coarse, fine}, 5'h1c);
        chk("ref ext", {ref_ext, cm_oe, ddr}, 3'h5);
        // fine 13 is refused, the other fields land
        bus(1, 8'h00, 32'h0000_01b0);
        repeat (2) @(negedge mclk);
        chk("gain kept", {coarse, fine}, 5'h1c);
        chk("ref int", {ref_ext, cm_oe, ddr}, 3'h2);
        bus(0, 8'h00, 0);
        chk("config back", rdata[10:0], 11'h190);
        // every power code, then back to normal
        for (int c = 0; c < 8; c++) begin
            bus(1, 8'h00, 32'(c));
            repeat (20) @(posedge sclk);
            @(negedge sclk);
            chk("link state", {oe_a, oe_b, val_a, val_b}, LINK_EXP[c]);
            if (c == 5) chk("standby word", data_a, 0);
            bus(1, 8'h00, 0);
            wait_valid();
            chk("wake time", (c == 4) ? (n > 200) : (n < 20), 1);
        end
        repeat (20) @(negedge sclk);
        #5;
        chk("word a", rx_a, 14'(conv - 14'h00f));
        chk("word b", rx_b, 14'(~(conv - 14'h00f)));
        // pin mode: code 110 and ddr from the pins, msb first
        @(posedge mclk);
        {pin_msb, pin_mid, pin_lsb, sen_pin} <= 4'hd;
        bus(1, 8'h00, 32'h0000_0008);
        repeat (8) @(negedge mclk);
        bus(0, 8'h04, 0);
        chk("pin code", {ddr, rdata[6], rdata[2:0]}, 5'h1e);
        repeat (20) @(posedge sclk);
        @(negedge sclk);
        chk("pin standby", {oe_a, oe_b, val_a, val_b}, 4'he);
        @(posedge mclk);
        {pin_msb, pin_mid, pin_lsb, sen_pin} <= 4'h0;
        bus(1, 8'h00, 0);
        wait_valid();
        // stop the sample clock
        @(posedge mclk);
        srun <= 1'b0;
        repeat (80) @(negedge mclk);
        bus(0, 8'h04, 0);
        chk("clock stop", {low_pwr, rdata[3]}, 2'h3);
        @(posedge mclk);
        srun <= 1'b1;
        repeat (10) @(posedge sclk);
        wait_valid();
        chk("stop wake", n > 150, 1);
        print_verdict();
    end
endmodule : testbench

bind dual_adc_mode_control mode_checker u_chk (.MCLK(MCLK), .RESET(RESET), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA),
    .GAIN_COARSE_EN(GAIN_COARSE_EN), .GAIN_FINE(GAIN_FINE), .REF_EXTERNAL(REF_EXTERNAL),
    .COMMON_MODE_PIN_OE(COMMON_MODE_PIN_OE), .LOW_POWER(LOW_POWER), .SAMPLE_CLK(SAMPLE_CLK),
    .CONV_B(CONV_B), .DATA_B(DATA_B), .DATA_A_OE(DATA_A_OE), .DATA_B_OE(DATA_B_OE),
    .VALID_B(VALID_B), .MUX_CHANNEL_B(MUX_CHANNEL_B), .OUTPUT_SAMPLE_CLK(OUTPUT_SAMPLE_CLK));
